// file: include/fmc_pkg.sv
// Package for the fault mask and input config block.
// Holds register offsets, field positions, reset values,
// filter delay times and the carrier structs.
// Assumes a 10 MHz core clock and an 8-bit register port.
package fmc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_FAULT_ALERT_MASK = 8'h02;
	localparam logic [7:0] ADDR_CHANNEL_ONE_CONFIG = 8'h03;
	localparam logic [7:0] RST_FAULT_ALERT_MASK = 8'h26;
	localparam logic [7:0] RST_CHANNEL_ONE_CONFIG = 8'h0c;
	// Bits 6 and 0 of the mask are reserved and read zero
	localparam logic [7:0] MASK_WRITABLE = 8'hbe;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MSK_CRC = 7;
	localparam int MSK_SUM = 5;
	localparam int MSK_OT = 4;
	localparam int MSK_TA = 3;
	localparam int MSK_UV = 2;
	localparam int MSK_VM = 1;
	localparam int CFG_THR = 7;
	localparam int CFG_SRC = 6;
	localparam int CFG_CUR_LSB = 4;
	localparam int CFG_FEN = 3;
	localparam int CFG_DLY_LSB = 0;
	localparam logic [1:0] CUR_HIZ = 2'h0;
	localparam logic [1:0] CUR_TTL = 2'h3;

	// ------------------------------------------------------------
	// Glitch filter delays
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned DLY0_NS = 50000;
	localparam int unsigned DLY1_NS = 100000;
	localparam int unsigned DLY2_NS = 400000;
	localparam int unsigned DLY3_NS = 800000;
	localparam int unsigned DLY4_NS = 1600000;
	localparam int unsigned DLY5_NS = 3200000;
	localparam int unsigned DLY6_NS = 12800000;
	localparam int unsigned DLY7_NS = 20000000;
	localparam int unsigned DLY0_CYC = DLY0_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY1_CYC = DLY1_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY2_CYC = DLY2_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY3_CYC = DLY3_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY4_CYC = DLY4_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY5_CYC = DLY5_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY6_CYC = DLY6_NS / CLK_PERIOD_NS;
	localparam int unsigned DLY7_CYC = DLY7_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 18;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic crc;
		logic ot;
		logic ta;
		logic uv;
		logic vm;
	} fmc_flags_t;

	typedef struct packed {
		logic threshold_high;
		logic source;
		logic [1:0] current_scale;
		logic ttl_mode;
		logic high_impedance_threshold_mode;
		logic glitch_filter_enable;
		logic [2:0] glitch_filter_delay;
	} fmc_ch1_ctl_t;

	// Sync order: crc enable, ot, ta, uv, vm, field input
	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [7:0] mask;
		logic [7:0] cfg;
		fmc_flags_t flags;
		logic summary;
		logic alert_n;
		logic [7:0] rdata;
		logic rvalid;
		fmc_ch1_ctl_t ctl;
	} fmc_top_state_t;

	typedef struct packed {
		logic out;
		logic [CNT_W-1:0] cnt;
	} fmc_filt_state_t;

	// Unmasked first-level sources, one bit per mask position
	function automatic logic [7:0] fmc_active(input fmc_flags_t f, input logic sum, input logic [7:0] m);
		logic [7:0] a;
		a = 8'h00;
		a[MSK_CRC] = f.crc & ~m[MSK_CRC];
		a[MSK_SUM] = sum & ~m[MSK_SUM];
		a[MSK_OT] = f.ot & ~m[MSK_OT];
		a[MSK_TA] = f.ta & ~m[MSK_TA];
		a[MSK_UV] = f.uv & ~m[MSK_UV];
		a[MSK_VM] = f.vm & ~m[MSK_VM];
		return a;
	endfunction : fmc_active

endpackage : fmc_pkg

// file: verilog/fmc_glitch_filter.sv
// Glitch filter for the channel one field input.
// Assumes i_in is already synchronised to i_clk.
`timescale 1ns/1ps
module fmc_glitch_filter #(
	parameter int P_CNT_W = 18,
	parameter logic [8*P_CNT_W-1:0] P_LIMITS = '1
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_in,
	input wire logic i_enable,
	input wire logic [2:0] i_delay_code,
	output logic o_out
);

	fmc_pkg::fmc_filt_state_t st_r;
	fmc_pkg::fmc_filt_state_t st_nxt;
	logic [P_CNT_W-1:0] lim;

	// Counter width is carried by the shared state struct, so it cannot differ
	if (P_CNT_W != fmc_pkg::CNT_W)
	begin : g_bad_width
		$error("filter counter width must match the shared state struct");
	end

	// ------------------------------------------------------------
	// Filter
	// ------------------------------------------------------------
	assign lim = P_LIMITS[i_delay_code*P_CNT_W +: P_CNT_W];

	// While enabled, output follows only after the new level held for the full delay
	always_comb
	begin
		st_nxt = st_r;
		if (!i_enable)
		begin
			st_nxt.out = i_in;
			st_nxt.cnt = '0;
		end
		else if (i_in == st_r.out)
		begin
			st_nxt.cnt = '0;
		end
		else if (st_r.cnt >= lim - P_CNT_W'(1))
		begin
			st_nxt.out = i_in;
			st_nxt.cnt = '0;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + P_CNT_W'(1);
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_out = st_r.out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_filter_bypass: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!i_enable |=> o_out == $past(i_in))
		else $error("filter bypass did not follow input");

	a_filter_delay: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$past(i_enable) && o_out != $past(o_out) |-> $past(st_r.cnt) == $past(lim) - P_CNT_W'(1))
		else $error("filtered output changed before delay");

	c_filter_change: cover property (@(posedge i_clk) disable iff (!i_reset_n)
		i_enable ##1 $changed(o_out));

endmodule : fmc_glitch_filter

// file: verilog/fmc_top.sv
// Fault alert mask and channel one configuration registers.
// Assumes the serial frame logic on i_clk drives the register port
// and the CRC error pulse; fault levels and the field input are pins.
//
// Behaviour
// - Unmasked frame check error flag drives fault alert; mask bit 7 blocks it.
// - Mask bit 5 gates the second-level fault summary onto fault alert.
// - Mask bit 4 gates the thermal shutdown flag onto fault alert.
// - Mask bit 3 gates the temperature alarm flag onto fault alert.
// - Mask bit 2 gates the field supply undervoltage flag onto fault alert.
// - Mask register is read/write; bit 1 gates low voltage; bits 6,0 reserved.
// - Config bit 7 picks high threshold, only for current codes 0 to 2.
// - Config bit 6 selects sink (0) or source (1) mode.
// - Current field: 0 off with high-Z threshold, 1x, 3x, 3 TTL.
// - Config bit 3 enables the glitch filter; zero bypasses it.
// - Delay field picks 50us up to 20ms filter delay.
// - Summary is OR of unmasked second-level bits, clearing by itself.
// - Frame check errors are only flagged while the enable input is high.
`timescale 1ns/1ps
module fmc_top #(
	parameter int unsigned P_DLY3_CYC = fmc_pkg::DLY3_CYC,
	parameter int unsigned P_DLY4_CYC = fmc_pkg::DLY4_CYC,
	parameter int unsigned P_DLY5_CYC = fmc_pkg::DLY5_CYC,
	parameter int unsigned P_DLY6_CYC = fmc_pkg::DLY6_CYC,
	parameter int unsigned P_DLY7_CYC = fmc_pkg::DLY7_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [fmc_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic i_frame_check_error,
	input wire logic i_frame_check_enable_input,
	input wire logic i_thermal_shutdown,
	input wire logic i_temperature_alarm,
	input wire logic i_field_supply_undervoltage,
	input wire logic i_low_comparator_voltage,
	input wire logic i_first_level_fault_status_read_clear,
	input wire logic [7:0] i_second_level_unmasked,
	input wire logic i_ch1_field_input,
	output logic o_fault_alert_n,
	output logic [7:0] o_first_level_fault_status,
	output fmc_pkg::fmc_ch1_ctl_t o_ch1_ctl,
	output logic o_ch1_state
);

	localparam int W = fmc_pkg::CNT_W;
	localparam logic [8*W-1:0] LIMITS = {
		W'(P_DLY7_CYC), W'(P_DLY6_CYC), W'(P_DLY5_CYC), W'(P_DLY4_CYC),
		W'(P_DLY3_CYC), W'(fmc_pkg::DLY2_CYC), W'(fmc_pkg::DLY1_CYC),
		W'(fmc_pkg::DLY0_CYC)};

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	// Counter is fixed at 18 bits; longer delays would wrap
	if (P_DLY3_CYC < 1 || P_DLY4_CYC < 1 || P_DLY5_CYC < 1 ||
		P_DLY6_CYC < 1 || P_DLY7_CYC < 1)
	begin : g_bad_min
		$error("filter delay counts must be at least one");
	end
	if (P_DLY3_CYC >= (1 << W) || P_DLY4_CYC >= (1 << W) ||
		P_DLY5_CYC >= (1 << W) || P_DLY6_CYC >= (1 << W) ||
		P_DLY7_CYC >= (1 << W))
	begin : g_bad_max
		$error("filter delay counts exceed counter width");
	end

	fmc_pkg::fmc_top_state_t st_r;
	fmc_pkg::fmc_top_state_t st_nxt;
	logic [5:0] pins;
	logic crc_en_s;
	logic [7:0] active;

	assign pins = {i_frame_check_enable_input, i_thermal_shutdown,
		i_temperature_alarm, i_field_supply_undervoltage,
		i_low_comparator_voltage, i_ch1_field_input};
	assign crc_en_s = st_r.sync2[5];
	// Uses registered flags so the alert is a clean flop output
	assign active = fmc_pkg::fmc_active(st_r.flags, st_r.summary, st_r.mask);

	// Current field decode, shared by the mode flags and the threshold gate;
	// one place to change if the field ever moves
	function automatic logic [1:0] cur_code(input logic [7:0] c);
		return c[fmc_pkg::CFG_CUR_LSB +: 2];
	endfunction : cur_code

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		// Two-stage synchronisers for all pin inputs
		st_nxt.sync1 = pins;
		st_nxt.sync2 = st_r.sync1;

		// Register writes; reserved mask bits never stored
		if (i_reg_wr && i_reg_addr == fmc_pkg::ADDR_FAULT_ALERT_MASK)
			st_nxt.mask = i_reg_wdata & fmc_pkg::MASK_WRITABLE;
		if (i_reg_wr && i_reg_addr == fmc_pkg::ADDR_CHANNEL_ONE_CONFIG)
			st_nxt.cfg = i_reg_wdata;

		// Register reads; unmapped offsets answer zero
		st_nxt.rvalid = i_reg_rd;
		st_nxt.rdata = 8'h00;
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				fmc_pkg::ADDR_FAULT_ALERT_MASK: st_nxt.rdata = st_r.mask;
				fmc_pkg::ADDR_CHANNEL_ONE_CONFIG: st_nxt.rdata = st_r.cfg;
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		// Sticky flags; a new event wins over a clear in the same cycle
		st_nxt.flags.crc = (st_r.flags.crc & ~i_first_level_fault_status_read_clear) |
			(i_frame_check_error & crc_en_s);
		st_nxt.flags.ot = (st_r.flags.ot & ~i_first_level_fault_status_read_clear) | st_r.sync2[4];
		st_nxt.flags.ta = (st_r.flags.ta & ~i_first_level_fault_status_read_clear) | st_r.sync2[3];
		st_nxt.flags.uv = (st_r.flags.uv & ~i_first_level_fault_status_read_clear) | st_r.sync2[2];
		st_nxt.flags.vm = (st_r.flags.vm & ~i_first_level_fault_status_read_clear) | st_r.sync2[1];

		// Summary is not sticky; it drops when the source bits drop
		st_nxt.summary = |i_second_level_unmasked;

		// Alert pin is active low, any unmasked source pulls it
		st_nxt.alert_n = ~|active;

		// Decoded channel controls toward the analog front end
		st_nxt.ctl.current_scale = cur_code(st_r.cfg);
		st_nxt.ctl.ttl_mode = cur_code(st_r.cfg) == fmc_pkg::CUR_TTL;
		st_nxt.ctl.high_impedance_threshold_mode =
			cur_code(st_r.cfg) == fmc_pkg::CUR_HIZ;
		// Threshold select is meaningless in TTL mode, so force it low
		st_nxt.ctl.threshold_high = st_r.cfg[fmc_pkg::CFG_THR] &
			(cur_code(st_r.cfg) != fmc_pkg::CUR_TTL);
		st_nxt.ctl.source = st_r.cfg[fmc_pkg::CFG_SRC];
		st_nxt.ctl.glitch_filter_enable = st_r.cfg[fmc_pkg::CFG_FEN];
		st_nxt.ctl.glitch_filter_delay = st_r.cfg[fmc_pkg::CFG_DLY_LSB +: 3];
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st_r <= '0;
			st_r.mask <= fmc_pkg::RST_FAULT_ALERT_MASK;
			st_r.cfg <= fmc_pkg::RST_CHANNEL_ONE_CONFIG;
			st_r.alert_n <= 1'b1;
			// Decoded controls start from the config reset value
			st_r.ctl.threshold_high <= fmc_pkg::RST_CHANNEL_ONE_CONFIG[fmc_pkg::CFG_THR];
			st_r.ctl.source <= fmc_pkg::RST_CHANNEL_ONE_CONFIG[fmc_pkg::CFG_SRC];
			st_r.ctl.current_scale <= fmc_pkg::RST_CHANNEL_ONE_CONFIG[fmc_pkg::CFG_CUR_LSB +: 2];
			st_r.ctl.glitch_filter_enable <= fmc_pkg::RST_CHANNEL_ONE_CONFIG[fmc_pkg::CFG_FEN];
			st_r.ctl.glitch_filter_delay <= fmc_pkg::RST_CHANNEL_ONE_CONFIG[fmc_pkg::CFG_DLY_LSB +: 3];
			st_r.ctl.high_impedance_threshold_mode <=
				fmc_pkg::RST_CHANNEL_ONE_CONFIG[fmc_pkg::CFG_CUR_LSB +: 2] == fmc_pkg::CUR_HIZ;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Field input filter
	// ------------------------------------------------------------
	// Filter settings come from the config register directly so a
	// delay change takes effect on the next clock
	fmc_glitch_filter #(
		.P_CNT_W(W),
		.P_LIMITS(LIMITS)
	) u_filter (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_in(st_r.sync2[0]),
		.i_enable(st_r.cfg[fmc_pkg::CFG_FEN]),
		.i_delay_code(st_r.cfg[fmc_pkg::CFG_DLY_LSB +: 3]),
		.o_out(o_ch1_state)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_reg_rdata = st_r.rdata;
	assign o_reg_rvalid = st_r.rvalid;
	assign o_fault_alert_n = st_r.alert_n;
	assign o_ch1_ctl = st_r.ctl;
	// Power-on bit is owned by the supply monitor, shown as zero here
	assign o_first_level_fault_status = {st_r.flags.crc, 1'b0, st_r.summary,
		st_r.flags.ot, st_r.flags.ta, st_r.flags.uv, st_r.flags.vm, 1'b0};

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	a_crc_alert: assert property (
		st_r.flags.crc && !st_r.mask[fmc_pkg::MSK_CRC] |=> !o_fault_alert_n)
		else $error("unmasked frame check error did not alert");

	a_summary_alert: assert property (
		(|i_second_level_unmasked) && !st_r.mask[fmc_pkg::MSK_SUM]
		&& !$past(i_reg_wr) && !i_reg_wr |=> ##1 !o_fault_alert_n)
		else $error("unmasked second-level summary did not alert");

	a_thermal_alert: assert property (
		st_r.flags.ot && !st_r.mask[fmc_pkg::MSK_OT] |=> !o_fault_alert_n)
		else $error("unmasked thermal shutdown did not alert");

	a_temp_alert: assert property (
		st_r.flags.ta && !st_r.mask[fmc_pkg::MSK_TA] |=> !o_fault_alert_n)
		else $error("unmasked temperature alarm did not alert");

	a_uv_alert: assert property (
		st_r.flags.uv && !st_r.mask[fmc_pkg::MSK_UV] |=> !o_fault_alert_n)
		else $error("unmasked undervoltage did not alert");

	a_vm_alert: assert property (
		st_r.flags.vm && !st_r.mask[fmc_pkg::MSK_VM] |=> !o_fault_alert_n)
		else $error("unmasked low voltage did not alert");

	a_mask_readback: assert property (
		i_reg_wr && i_reg_addr == fmc_pkg::ADDR_FAULT_ALERT_MASK ##1
		i_reg_rd && i_reg_addr == fmc_pkg::ADDR_FAULT_ALERT_MASK && !i_reg_wr
		|=> o_reg_rvalid && o_reg_rdata == ($past(i_reg_wdata, 2) & fmc_pkg::MASK_WRITABLE))
		else $error("mask readback mismatch");

	a_thr_select: assert property (
		i_reg_wr && i_reg_addr == fmc_pkg::ADDR_CHANNEL_ONE_CONFIG |=> ##1
		o_ch1_ctl.threshold_high == ($past(i_reg_wdata[7], 2) && $past(i_reg_wdata[5:4], 2) != 2'h3))
		else $error("threshold select wrong for current code");

	a_mode_decode: assert property (
		i_reg_wr && i_reg_addr == fmc_pkg::ADDR_CHANNEL_ONE_CONFIG |=> ##1
		o_ch1_ctl.source == $past(i_reg_wdata[6], 2) &&
		o_ch1_ctl.ttl_mode == ($past(i_reg_wdata[5:4], 2) == 2'h3) &&
		o_ch1_ctl.high_impedance_threshold_mode == ($past(i_reg_wdata[5:4], 2) == 2'h0))
		else $error("source or current mode decode wrong");

	a_crc_gated: assert property (
		$rose(st_r.flags.crc) |-> $past(crc_en_s) && $past(i_frame_check_error))
		else $error("frame check flag set without enable");

	a_summary_clear: assert property (
		!(|i_second_level_unmasked) |=> !st_r.summary)
		else $error("summary did not clear with its sources");

	a_alert_release: assert property (
		active == 8'h00 |=> o_fault_alert_n)
		else $error("alert held with no unmasked source");

	a_alert_assert: assert property (
		active != 8'h00 |=> !o_fault_alert_n)
		else $error("alert not asserted with an unmasked source");

	// A held event must survive a clear pulse in the same cycle
	a_flag_sticky: assert property (
		st_r.sync2[4] |=> st_r.flags.ot)
		else $error("thermal flag lost while its event was present");

	// ------------------------------------------------------------
	// Register port and decode checks
	// ------------------------------------------------------------
	a_read_valid: assert property (
		i_reg_rd |=> o_reg_rvalid)
		else $error("read strobe gave no valid answer");

	a_read_idle: assert property (
		!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00)
		else $error("read answer shown without a read");

	a_reserved_zero: assert property (
		!st_r.mask[6] && !st_r.mask[0])
		else $error("reserved mask bit stored");

	a_cfg_readback: assert property (
		i_reg_wr && i_reg_addr == fmc_pkg::ADDR_CHANNEL_ONE_CONFIG ##1
		i_reg_rd && i_reg_addr == fmc_pkg::ADDR_CHANNEL_ONE_CONFIG && !i_reg_wr
		|=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("config readback mismatch");

	a_ttl_no_high: assert property (
		o_ch1_ctl.ttl_mode |-> !o_ch1_ctl.threshold_high)
		else $error("high threshold shown in TTL mode");

	c_crc_alert: cover property (st_r.flags.crc && !st_r.mask[7] ##1 !o_fault_alert_n);
	c_sum_alert: cover property (st_r.summary && !st_r.mask[5] ##1 !o_fault_alert_n);
	c_ttl_mode: cover property (o_ch1_ctl.ttl_mode && o_ch1_ctl.source);
	c_clear_race: cover property (i_first_level_fault_status_read_clear && st_r.sync2[4]);

endmodule : fmc_top

// file: verification/fmc_host_model.sv
// Host controller model: issues register reads and writes.
// Assumes callers run on the falling edge of i_clk.
`timescale 1ns/1ps
module fmc_host_model (
	input wire logic i_clk,
	input wire logic i_rvalid,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	// Idle bus; released lines show the inverse so stale values never match
	initial
	begin
		o_wr = 1'h0;
		o_rd = 1'h0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] dat);
		@(negedge i_clk);
		o_wr = 1'h1;
		o_addr = a;
		o_wdata = dat;
		@(negedge i_clk);
		o_wr = 1'h0;
		o_addr = ~a;
		o_wdata = ~dat;
	endtask : wr

	// One-cycle read strobe; answer is taken one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic vld);
		@(negedge i_clk);
		o_rd = 1'h1;
		o_addr = a;
		@(negedge i_clk);
		dat = i_rdata;
		vld = i_rvalid;
		o_rd = 1'h0;
		o_addr = ~a;
	endtask : rd

	// Write, then a read of the same offset on the very next edge
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] dat, output logic [7:0] rdat, output logic vld);
		@(negedge i_clk);
		o_wr = 1'h1;
		o_addr = a;
		o_wdata = dat;
		@(negedge i_clk);
		o_wr = 1'h0;
		o_rd = 1'h1;
		o_wdata = ~dat;
		@(negedge i_clk);
		rdat = i_rdata;
		vld = i_rvalid;
		o_rd = 1'h0;
		o_addr = ~a;
	endtask : wr_rd
endmodule : fmc_host_model

// file: verification/testbench.sv
// Self-checking bench for the fault mask and channel one config block.
// Assumes a 10 MHz clock and shortened filter counts for codes 3 to 7.
`timescale 1ns/1ps
module testbench;
	typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} fmc_tb_row_t;
	logic clk, reset_n, ce, crc, ot, ta, uv, vm, rclr, fin, wr, rd, rvalid, alert_n, state, v;
	logic [7:0] sl, addr, wd, rdata, status, d;
	fmc_pkg::fmc_ch1_ctl_t ctl;
	int mismatches, compares;
	int pos[6] = '{7, 5, 4, 3, 2, 1};
	int lims[8] = '{500, 1000, 4000, 20, 30, 40, 50, 60};
	fmc_tb_row_t rows[8] = '{'{8'h02, 8'hff, 8'hbe}, '{8'h02, 8'h41, 8'h00}, '{8'h03, 8'h80, 8'h80},
		'{8'h03, 8'hd9, 8'hd9}, '{8'h03, 8'ha2, 8'ha2}, '{8'h03, 8'hb3, 8'hb3},
		'{8'h03, 8'h44, 8'h44}, '{8'h03, 8'h7f, 8'h7f}};

	fmc_top #(.P_DLY3_CYC(20), .P_DLY4_CYC(30), .P_DLY5_CYC(40), .P_DLY6_CYC(50), .P_DLY7_CYC(60)) dut_u (
		.i_clk(clk), .i_reset_n(reset_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
		.i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_frame_check_error(crc),
		.i_frame_check_enable_input(ce), .i_thermal_shutdown(ot), .i_temperature_alarm(ta),
		.i_field_supply_undervoltage(uv), .i_low_comparator_voltage(vm), .i_first_level_fault_status_read_clear(rclr),
		.i_second_level_unmasked(sl), .i_ch1_field_input(fin), .o_fault_alert_n(alert_n),
		.o_first_level_fault_status(status), .o_ch1_ctl(ctl), .o_ch1_state(state));

	fmc_host_model host_u (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
		.o_addr(addr), .o_wdata(wd));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Decoded controls worked out from the field meanings
	function automatic logic [9:0] exp_ctl(input logic [7:0] c);
		return {c[7] & (c[5:4] != 2'h3), c[6], c[5:4], c[5:4] == 2'h3, c[5:4] == 2'h0, c[3], c[2:0]};
	endfunction : exp_ctl

	task automatic chk_bit(input string n, input logic e, input logic g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit

	task automatic chk_vec(input string n, input logic [9:0] e, input logic [9:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk_vec

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n

	// Fault source i: level pins held, frame check error is a pulse
	task automatic src(input int i, input logic lv);
		@(negedge clk);
		case (i)
			0: crc = lv;
			1: sl = {3'h0, lv, 4'h0};
			2: ot = lv;
			3: ta = lv;
			4: uv = lv;
			default: vm = lv;
		endcase
		if (i == 0)
		begin
			@(negedge clk);
			crc = 1'h0;
		end
	endtask : src

	task automatic clear_flags();
		@(negedge clk);
		rclr = 1'h1;
		@(negedge clk);
		rclr = 1'h0;
		wait_n(3);
	endtask : clear_flags

	task automatic close_out();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// Tests need about 6100 cycles; cut off well beyond that
	initial
	begin
		#4000000;
		mismatches++;
		close_out();
	end

	initial
	begin
		{reset_n, ce, crc, ot, ta, uv, vm, rclr, fin, sl} = 17'h0;
		mismatches = 0;
		compares = 0;
		wait_n(6);
		reset_n = 1'h1;
		ce = 1'h1;
		// Reset values and an unmapped read
		chk_bit("alert reset", 1'h1, alert_n);
		chk_vec("ctl reset", exp_ctl(8'h0c), ctl);
		host_u.rd(8'h02, d, v);
		chk_vec("mask reset", 10'h26, {2'h0, d});
		host_u.rd(8'h03, d, v);
		chk_vec("cfg reset", 10'h0c, {2'h0, d});
		host_u.rd(8'h05, d, v);
		chk_vec("unmapped", 10'h000, {2'h0, d});
		chk_bit("unmapped rvalid", 1'h1, v);
		$display("test reset done");
		// Register rows: write, read back, decoded controls
		foreach (rows[k])
		begin
			host_u.wr(rows[k].a, rows[k].w);
			wait_n(1);
			host_u.rd(rows[k].a, d, v);
			chk_vec("readback", {2'h0, rows[k].e}, {2'h0, d});
			if (rows[k].a == 8'h03)
				chk_vec("ctl", exp_ctl(rows[k].w), ctl);
		end
		$display("test rows done");
		// Write followed at once by a read of the same register
		host_u.wr_rd(8'h02, 8'h7f, d, v);
		chk_vec("mask wr then rd", 10'h03e, {2'h0, d});
		host_u.wr_rd(8'h03, 8'h5a, d, v);
		chk_vec("cfg wr then rd", 10'h05a, {2'h0, d});
		$display("test write then read done");
		// Each first-level source masked, unmasked, then cleared
		foreach (pos[i])
		begin
			host_u.wr(8'h02, 8'hbe);
			src(i, 1'h1);
			wait_n(6);
			chk_bit("masked alert", 1'h1, alert_n);
			chk_bit("flag set", 1'h1, status[pos[i]]);
			host_u.wr(8'h02, 8'hbe & ~(8'h01 << pos[i]));
			wait_n(2);
			chk_bit("unmasked alert", 1'h0, alert_n);
			src(i, 1'h0);
			wait_n(4);
			if (i == 1)
				chk_bit("summary clears", 1'h0, status[5]);
			clear_flags();
			chk_bit("alert released", 1'h1, alert_n);
			chk_bit("flag clear", 1'h0, status[pos[i]]);
		end
		$display("test masks done");
		// Frame check errors ignored while the enable pin is low
		host_u.wr(8'h02, 8'h00);
		ce = 1'h0;
		wait_n(4);
		src(0, 1'h1);
		wait_n(4);
		chk_bit("crc disabled", 1'h0, status[7]);
		chk_bit("crc no alert", 1'h1, alert_n);
		ce = 1'h1;
		$display("test crc enable done");
		// Clear in the same cycle as a held event: the event wins
		src(2, 1'h1);
		wait_n(4);
		clear_flags();
		chk_bit("set wins", 1'h1, status[4]);
		chk_bit("alert held", 1'h0, alert_n);
		src(2, 1'h0);
		wait_n(4);
		clear_flags();
		chk_bit("ot cleared", 1'h0, status[4]);
		chk_bit("ot alert released", 1'h1, alert_n);
		$display("test clear race done");
		// Filter: short pulse dropped, then every delay code at its boundary
		host_u.wr(8'h03, 8'h0b);
		wait_n(2);
		fin = 1'h1;
		wait_n(10);
		fin = 1'h0;
		wait_n(40);
		chk_bit("pulse dropped", 1'h0, state);
		foreach (lims[k])
		begin
			host_u.wr(8'h03, 8'h08 | k[7:0]);
			wait_n(2);
			fin = ~fin;
			wait_n(lims[k] - 2);
			chk_bit("filter early", ~fin, state);
			wait_n(10);
			chk_bit("filter late", fin, state);
		end
		// Bypass: output follows within three edges
		host_u.wr(8'h03, 8'h00);
		wait_n(2);
		fin = ~fin;
		wait_n(4);
		chk_bit("bypass", fin, state);
		$display("test filter done");
		// Reset in mid-run brings back every reset value
		reset_n = 1'h0;
		wait_n(2);
		reset_n = 1'h1;
		chk_bit("alert mid reset", 1'h1, alert_n);
		chk_bit("state mid reset", 1'h0, state);
		chk_vec("ctl mid reset", exp_ctl(8'h0c), ctl);
		host_u.rd(8'h02, d, v);
		chk_vec("mask mid reset", 10'h26, {2'h0, d});
		host_u.rd(8'h03, d, v);
		chk_vec("cfg mid reset", 10'h0c, {2'h0, d});
		$display("test mid reset done");
		close_out();
	end
endmodule : testbench
